//--- exi_params.svh
// Register offsets, field positions and encodings of the external interrupt block.
`ifndef EXI_PARAMS_SVH
`define EXI_PARAMS_SVH
`define EXI_OFS_SENSE 8'h00
`define EXI_OFS_MASK 8'h04
`define EXI_OFS_FLAGS 8'h08
`define EXI_OFS_PCCTL 8'h0C
`define EXI_OFS_PCFLG 8'h10
`define EXI_OFS_PCM_LO 8'h14
`define EXI_OFS_PCM_MID 8'h18
`define EXI_OFS_PCM_HI 8'h1C
`define EXI_SNS_A_LSB 0
`define EXI_SNS_B_LSB 2
`define EXI_SNS_LOW 2'h0
`define EXI_SNS_ANY 2'h1
`define EXI_SNS_FALL 2'h2
`define EXI_SNS_RISE 2'h3
`define EXI_MID_MASK 8'h7F
`define EXI_GRP_LO_LSB 0
`define EXI_GRP_MID_LSB 8
`define EXI_GRP_HI_LSB 16
`define EXI_REQ_A 0
`define EXI_REQ_B 1
`define EXI_REQ_PC 2
`define EXI_RESET_VAL '0
`endif

//--- exi_pkg.sv
// Types shared by the external interrupt block.
`default_nettype none
package exi_pkg;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } exi_apb_req_t;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } exi_apb_rsp_t;
   typedef struct packed {
      logic [3:0] sense;
      logic [1:0] mask;
      logic [1:0] flags;
      logic [2:0] pcie;
      logic [2:0] pcflg;
      logic [7:0] pcm_lo;
      logic [7:0] pcm_mid;
      logic [7:0] pcm_hi;
      logic [1:0] lvl;
      logic [1:0] pin_cur;
      logic [1:0] pin_prev;
      logic pin_ok;
      logic [23:0] pc_cur;
      logic [23:0] pc_prev;
      logic pc_ok;
      exi_apb_rsp_t rsp;
      logic [4:0] req;
   } exi_state_t;
endpackage
`default_nettype wire

//--- exi_top.sv
// External pin interrupt logic: two sense-controlled pins and 24 pin-change inputs.
//
// Behaviour
// RL1 - Requests come from pin levels whatever the pin direction, so software can trigger.
// RL2 - Group hi covers inputs 23..16, mid 14..8, lo 7..0.
// RL3 - Each group has a per-pin mask gating its toggles; lo and hi have 8 bits, mid 7 (bit 7 reads zero).
// RL4 - Pin-change detection does not depend on the I/O clock running.
// RL5 - Pin edges on the sense pins are seen only while the I/O clock runs.
// RL6 - Low level on the sense pins is seen without the I/O clock.
// RL7 - Level mode keeps requesting for as long as the pin is low.
// RL8 - For level wake-up the source holds low past start-up, else no request.
// RL9 - Pin b sense at bits 3:2: low, any change, falling, rising.
// RL10 - Pin a sense at bits 1:0 with the same encoding.
// RL11 - Pins are sampled before edge detection; pulses over one clock are caught.
// RL12 - In level mode the source holds low until the current instruction ends.
// RL13 - Mask bit 1 enables pin b only with global enable; own vector.
// RL14 - Mask bit 0 enables pin a only with global enable; own vector.
// RL15 - Sense register bits 7..4 read zero.
// RL16 - Mask register bits 7..2 read zero.
// RL17 - Pin flags set on trigger, clear on vector or write-one, zero in level mode.
// RL18 - Group enables at bits 2..0 with global gate; group flags clear like pin flags.
// RL19 - Edges compare the current pin sample with the previous I/O-clock sample.
`timescale 1ns/10ps
`default_nettype none
`include "exi_params.svh"

module exi_top (
   // Clock, reset and enables.
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire logic io_clk_run_i,
   // Register bus.
   input wire exi_pkg::exi_apb_req_t apb_i,
   output exi_pkg::exi_apb_rsp_t apb_o,
   // Pins.
   input wire logic ext_irq_pin_a_i,
   input wire logic ext_irq_pin_b_i,
   input wire logic [23:0] pin_change_inputs_i,
   // Core side.
   input wire logic global_irq_en_i,
   input wire logic [4:0] vec_ack_i,
   output logic [4:0] irq_req_o
);

   exi_pkg::exi_state_t s_r;
   exi_pkg::exi_state_t s_nxt;
   logic access;
   logic wr_now;
   logic [1:0] pin_hit;
   logic [23:0] pc_tog;
   logic [2:0] pc_hit;
   logic [1:0] flg_clr;
   logic [2:0] pcf_clr;
   logic [31:0] rd_mux;
   logic rd_bad;

   function automatic logic fire(input logic [1:0] sns, input logic cur, input logic prv);
      logic f;
      f = 1'b0;
      case (sns)
         `EXI_SNS_ANY: f = cur ^ prv;
         `EXI_SNS_FALL: f = prv & ~cur;
         `EXI_SNS_RISE: f = cur & ~prv;
         default: f = 1'b0;
      endcase
      return f;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Event detection.

   // Level mode yields no edge hit, so the flag never sets there.
   assign pin_hit[0] = io_clk_run_i & s_r.pin_ok
      & fire(s_r.sense[`EXI_SNS_A_LSB +: 2], s_r.pin_cur[0], s_r.pin_prev[0]); // RL10 RL11 RL19
   assign pin_hit[1] = io_clk_run_i & s_r.pin_ok
      & fire(s_r.sense[`EXI_SNS_B_LSB +: 2], s_r.pin_cur[1], s_r.pin_prev[1]); // RL9 RL11 RL19

   assign pc_tog = s_r.pc_ok ? (s_r.pc_cur ^ s_r.pc_prev) : 24'h000000; // RL4
   assign pc_hit[0] = |(pc_tog[`EXI_GRP_LO_LSB +: 8] & s_r.pcm_lo); // RL2 RL3
   assign pc_hit[1] = |(pc_tog[`EXI_GRP_MID_LSB +: 8] & s_r.pcm_mid & `EXI_MID_MASK); // RL2 RL3
   assign pc_hit[2] = |(pc_tog[`EXI_GRP_HI_LSB +: 8] & s_r.pcm_hi); // RL2 RL3

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode.

   assign access = apb_i.psel & apb_i.penable;
   assign wr_now = access & s_r.rsp.pready & apb_i.pwrite;

   assign flg_clr = vec_ack_i[`EXI_REQ_B:`EXI_REQ_A]
      | ((wr_now && apb_i.paddr == `EXI_OFS_FLAGS) ? apb_i.pwdata[1:0] : 2'h0);
   assign pcf_clr = vec_ack_i[`EXI_REQ_PC +: 3]
      | ((wr_now && apb_i.paddr == `EXI_OFS_PCFLG) ? apb_i.pwdata[2:0] : 3'h0);

   always_comb begin
      rd_mux = 32'h00000000;
      rd_bad = 1'b0;
      case (apb_i.paddr)
         `EXI_OFS_SENSE: rd_mux = {28'h0000000, s_r.sense}; // RL15
         `EXI_OFS_MASK: rd_mux = {30'h00000000, s_r.mask}; // RL16
         `EXI_OFS_FLAGS: rd_mux = {30'h00000000, s_r.flags};
         `EXI_OFS_PCCTL: rd_mux = {29'h00000000, s_r.pcie};
         `EXI_OFS_PCFLG: rd_mux = {29'h00000000, s_r.pcflg};
         `EXI_OFS_PCM_LO: rd_mux = {24'h000000, s_r.pcm_lo};
         `EXI_OFS_PCM_MID: rd_mux = {24'h000000, s_r.pcm_mid};
         `EXI_OFS_PCM_HI: rd_mux = {24'h000000, s_r.pcm_hi};
         default: rd_bad = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state.

   always_comb begin
      s_nxt = s_r;
      if (clk_en_i) begin
         // Pin levels are taken as seen on the pad, output or not.
         s_nxt.lvl = {ext_irq_pin_b_i, ext_irq_pin_a_i}; // RL1 RL6
         s_nxt.pc_cur = pin_change_inputs_i; // RL1 RL4
         // The first sample after reset fills both history stages, so no edge is seen against zeros.
         s_nxt.pc_prev = s_r.pc_ok ? s_r.pc_cur : pin_change_inputs_i;
         s_nxt.pc_ok = 1'b1;
         if (io_clk_run_i) begin
            s_nxt.pin_cur = {ext_irq_pin_b_i, ext_irq_pin_a_i}; // RL5 RL11
            s_nxt.pin_prev = s_r.pin_ok ? s_r.pin_cur : {ext_irq_pin_b_i, ext_irq_pin_a_i}; // RL19
            s_nxt.pin_ok = 1'b1;
         end

         // A set in the same cycle as its clear wins.
         s_nxt.flags = (s_r.flags & ~flg_clr) | pin_hit; // RL17
         s_nxt.pcflg = (s_r.pcflg & ~pcf_clr) | pc_hit; // RL18

         if (access && !s_r.rsp.pready) begin
            s_nxt.rsp.pready = 1'b1;
            s_nxt.rsp.pslverr = rd_bad;
            s_nxt.rsp.prdata = apb_i.pwrite ? 32'h00000000 : rd_mux;
         end else begin
            s_nxt.rsp.pready = 1'b0;
            s_nxt.rsp.pslverr = 1'b0;
         end

         if (wr_now) begin
            unique case (apb_i.paddr)
               `EXI_OFS_SENSE: s_nxt.sense = apb_i.pwdata[3:0]; // RL9 RL10
               `EXI_OFS_MASK: s_nxt.mask = apb_i.pwdata[1:0]; // RL13 RL14
               `EXI_OFS_PCCTL: s_nxt.pcie = apb_i.pwdata[2:0]; // RL18
               `EXI_OFS_PCM_LO: s_nxt.pcm_lo = apb_i.pwdata[7:0]; // RL3
               `EXI_OFS_PCM_MID: s_nxt.pcm_mid = apb_i.pwdata[7:0] & `EXI_MID_MASK; // RL3
               `EXI_OFS_PCM_HI: s_nxt.pcm_hi = apb_i.pwdata[7:0]; // RL3
               default: s_nxt.sense = s_r.sense;
            endcase
         end

         // Flags of a pin in level mode are held cleared.
         if (s_nxt.sense[`EXI_SNS_A_LSB +: 2] == `EXI_SNS_LOW) begin
            s_nxt.flags[0] = 1'b0; // RL17
         end
         if (s_nxt.sense[`EXI_SNS_B_LSB +: 2] == `EXI_SNS_LOW) begin
            s_nxt.flags[1] = 1'b0; // RL17
         end

         // Level requests follow the registered pin level (lvl) every clock-enabled cycle, edge ones the flag.
         s_nxt.req[`EXI_REQ_A] = global_irq_en_i & s_r.mask[0]
            & ((s_r.sense[`EXI_SNS_A_LSB +: 2] == `EXI_SNS_LOW) ? ~s_r.lvl[0]
               : s_r.flags[0]); // RL7 RL14
         s_nxt.req[`EXI_REQ_B] = global_irq_en_i & s_r.mask[1]
            & ((s_r.sense[`EXI_SNS_B_LSB +: 2] == `EXI_SNS_LOW) ? ~s_r.lvl[1]
               : s_r.flags[1]); // RL7 RL13
         s_nxt.req[`EXI_REQ_PC +: 3] = {3{global_irq_en_i}} & s_r.pcie & s_r.pcflg; // RL18
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         s_r <= `EXI_RESET_VAL;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign apb_o = s_r.rsp;
   assign irq_req_o = s_r.req;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // Edges as the edge detector sees them, with no register write in the same cycle.
   sequence s_rise_a;
      clk_en_i && io_clk_run_i && s_r.pin_ok && !wr_now
         && s_r.sense[1:0] == `EXI_SNS_RISE && s_r.pin_cur[0] && !s_r.pin_prev[0];
   endsequence

   sequence s_fall_b;
      clk_en_i && io_clk_run_i && s_r.pin_ok && !wr_now
         && s_r.sense[3:2] == `EXI_SNS_FALL && !s_r.pin_cur[1] && s_r.pin_prev[1];
   endsequence

   sequence s_any_a;
      clk_en_i && io_clk_run_i && s_r.pin_ok && !wr_now
         && s_r.sense[1:0] == `EXI_SNS_ANY && s_r.pin_cur[0] != s_r.pin_prev[0];
   endsequence

   sequence s_rise_b;
      clk_en_i && io_clk_run_i && s_r.pin_ok && !wr_now
         && s_r.sense[3:2] == `EXI_SNS_RISE && s_r.pin_cur[1] && !s_r.pin_prev[1];
   endsequence

   sequence s_read_sense;
      clk_en_i && access && !s_r.rsp.pready && !apb_i.pwrite
         && apb_i.paddr == `EXI_OFS_SENSE;
   endsequence

   sequence s_read_mask;
      clk_en_i && access && !s_r.rsp.pready && !apb_i.pwrite
         && apb_i.paddr == `EXI_OFS_MASK;
   endsequence

   // An enabled pin in level mode whose low level has been sampled.
   sequence s_level_a;
      clk_en_i && global_irq_en_i && s_r.mask[0]
         && s_r.sense[1:0] == `EXI_SNS_LOW && !s_r.lvl[0];
   endsequence

   sequence s_level_b;
      clk_en_i && global_irq_en_i && s_r.mask[1]
         && s_r.sense[3:2] == `EXI_SNS_LOW && !s_r.lvl[1];
   endsequence

   chk_rise_flag_a: assert property (s_rise_a |=> s_r.flags[0]) // RL10 RL11
      else $error("pin a rising edge did not set its flag");

   chk_fall_flag_b: assert property (s_fall_b |=> s_r.flags[1]) // RL9 RL11
      else $error("pin b falling edge did not set its flag");

   chk_any_flag_a: assert property (s_any_a |=> s_r.flags[0]) // RL10 RL11
      else $error("pin a change did not set its flag");

   chk_rise_flag_b: assert property (s_rise_b |=> s_r.flags[1]) // RL9 RL11
      else $error("pin b rising edge did not set its flag");

   chk_level_hold: assert property (s_level_a |=> irq_req_o[0]) // RL7 RL14
      else $error("low level on pin a did not request");

   chk_level_hold_b: assert property (s_level_b |=> irq_req_o[1]) // RL7 RL13
      else $error("low level on pin b did not request");

   chk_level_noflag: assert property (s_r.sense[1:0] == `EXI_SNS_LOW |-> !s_r.flags[0]) // RL17
      else $error("pin a flag set while in level mode");

   chk_noflag_b: assert property (s_r.sense[3:2] == `EXI_SNS_LOW |-> !s_r.flags[1]) // RL17
      else $error("pin b flag set while in level mode");

   chk_global_gate: assert property ( // RL13 RL14
      clk_en_i && !global_irq_en_i |=> irq_req_o == 5'h00)
      else $error("request raised with global enable off");

   chk_mask_gate_a: assert property ( // RL14
      clk_en_i && !s_r.mask[0] |=> !irq_req_o[0])
      else $error("pin a requested with its mask bit clear");

   chk_mask_gate_b: assert property ( // RL13
      clk_en_i && !s_r.mask[1] |=> !irq_req_o[1])
      else $error("pin b requested with its mask bit clear");

   chk_edge_req_a: assert property ( // RL14
      clk_en_i && global_irq_en_i && s_r.mask[0] && s_r.sense[1:0] != `EXI_SNS_LOW
         && s_r.flags[0] |=> irq_req_o[0])
      else $error("pin a flag with mask set did not request");

   chk_io_stop: assert property (!io_clk_run_i |=> $stable(s_r.pin_cur)) // RL5
      else $error("pin sample moved with I/O clock stopped");

   chk_lvl_free: assert property ( // RL6
      rst_n_i && clk_en_i |=> s_r.lvl[0] == $past(ext_irq_pin_a_i)
         && s_r.lvl[1] == $past(ext_irq_pin_b_i))
      else $error("level sample did not follow the pins");

   chk_pc_free: assert property ( // RL1 RL4
      rst_n_i && clk_en_i |=> s_r.pc_cur == $past(pin_change_inputs_i))
      else $error("pin-change sample did not follow the pins");

   chk_group_hi: assert property ( // RL2 RL4
      clk_en_i && s_r.pc_ok && |((s_r.pc_cur[23:16] ^ s_r.pc_prev[23:16]) & s_r.pcm_hi)
      |=> s_r.pcflg[2])
      else $error("masked toggle in group hi not flagged");

   chk_group_req: assert property ( // RL18
      clk_en_i && global_irq_en_i && s_r.pcie[2] && s_r.pcflg[2] |=> irq_req_o[4])
      else $error("group hi flag with enable did not request");

   chk_pc_set_wins: assert property ( // RL18
      rst_n_i && clk_en_i |=> (s_r.pcflg & $past(pc_hit)) == $past(pc_hit))
      else $error("group toggle lost against a clear");

   chk_pc_ack: assert property ( // RL18
      rst_n_i && clk_en_i && vec_ack_i[`EXI_REQ_PC] && !pc_hit[0] |=> !s_r.pcflg[0])
      else $error("group lo flag not cleared by its vector");

   chk_w1c_a: assert property ( // RL17
      rst_n_i && clk_en_i && wr_now && apb_i.paddr == `EXI_OFS_FLAGS && apb_i.pwdata[0]
         && !pin_hit[0] |=> !s_r.flags[0])
      else $error("pin a flag not cleared by a write of one");

   chk_mid_rsvd: assert property (s_r.pcm_mid[7] == 1'b0) // RL3
      else $error("group mid mask bit 7 not zero");

   chk_sense_rsvd: assert property ( // RL15
      s_read_sense |=> apb_o.pready && apb_o.prdata[31:4] == 28'h0000000)
      else $error("sense register upper bits not zero");

   chk_mask_rsvd: assert property ( // RL16
      s_read_mask |=> apb_o.pready && apb_o.prdata[31:2] == 30'h00000000)
      else $error("mask register upper bits not zero");

   chk_bad_addr: assert property (
      clk_en_i && access && !s_r.rsp.pready && rd_bad |=> apb_o.pready && apb_o.pslverr)
      else $error("unmapped access answered without an error");

   chk_freeze: assert property (rst_n_i && !clk_en_i |=> $stable(irq_req_o) && $stable(apb_o))
      else $error("outputs moved with the clock enable low");

endmodule
`default_nettype wire

//--- exi_pin_src.sv
// Pin source model: external drivers of the interrupt and pin-change pins.
`timescale 1ns/10ps
`default_nettype none
module exi_pin_src (
   // Clock and requested levels.
   input wire logic clk_i,
   input wire logic [25:0] want_i,
   // Pins: [0] pin a, [1] pin b, [25:2] pin-change inputs.
   output logic [25:0] pins_o
);
   // Levels move just after an edge and are held until the bench moves them.
   always_ff @(posedge clk_i) begin
      pins_o <= want_i;
   end
endmodule
`default_nettype wire

//--- exi_top_test.sv
// Self-checking bench for the external pin interrupt block.
`timescale 1ns/10ps
`default_nettype none
`include "exi_params.svh"
module exi_top_test;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic io_run = 1'b1;
   logic ce = 1'b1;
   logic gie = 1'b0;
   logic [4:0] ack = 5'h00;
   logic [25:0] want = 26'h3FFFFFF;
   logic [25:0] pins;
   logic [4:0] irq;
   logic [31:0] rd;
   logic err;
   exi_pkg::exi_apb_req_t req = '0;
   exi_pkg::exi_apb_rsp_t rsp;
   int num_errors = 0;
   int num_checks = 0;
   ////////////////////////////////////////
   exi_pin_src src (.clk_i(clk), .want_i(want), .pins_o(pins));
   exi_top uut (.sys_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(ce), .io_clk_run_i(io_run),
      .apb_i(req), .apb_o(rsp), .ext_irq_pin_a_i(pins[0]), .ext_irq_pin_b_i(pins[1]),
      .pin_change_inputs_i(pins[25:2]), .global_irq_en_i(gie), .vec_ack_i(ack),
      .irq_req_o(irq));
   ////////////////////////////////////////
   initial begin
      forever #2.5 clk = ~clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk);
      req.penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (rsp.pready !== 1'b1);
      chk("pready", rsp.pready, 1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
      @(posedge clk);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 0);
      chk(nm, rd, exp);
   endtask
   task automatic t_regs();
      chk("irq_rst", irq, 0);
      rdc("sense", `EXI_OFS_SENSE, 0);
      bus(1'b1, `EXI_OFS_SENSE, 32'hFF);
      rdc("sense", `EXI_OFS_SENSE, 32'h0F);
      bus(1'b1, `EXI_OFS_MASK, 32'hFF);
      rdc("mask", `EXI_OFS_MASK, 32'h03);
      bus(1'b1, `EXI_OFS_PCM_MID, 32'hFF);
      rdc("mask_mid", `EXI_OFS_PCM_MID, 32'h7F);
      rdc("unmapped", 8'hF0, 0);
      chk("pslverr", err, 1);
      $display("test regs done");
   endtask
   task automatic t_level();
      for (int p = 0; p < 2; p++) begin
         bus(1'b1, `EXI_OFS_SENSE, 0);
         bus(1'b1, `EXI_OFS_MASK, 1 << p);
         gie <= 1'b1;
         want[p] <= 1'b0;
         cyc(20);
         chk("irq_lvl", irq, 5'h01 << p);
         rdc("flags", `EXI_OFS_FLAGS, 0);
         ce <= 1'b0;
         gie <= 1'b0;
         cyc(4);
         chk("irq_frozen", irq, 5'h01 << p);
         ce <= 1'b1;
         cyc(3);
         chk("irq_gie", irq, 0);
         want[p] <= 1'b1;
         cyc(3);
      end
      $display("test level done");
   endtask
   task automatic t_sense();
      logic [1:0] b;
      gie <= 1'b1;
      for (int p = 0; p < 2; p++) begin
         for (int m = 1; m < 4; m++) begin
            bus(1'b1, `EXI_OFS_SENSE, m << (2 * p));
            bus(1'b1, `EXI_OFS_MASK, 1 << p);
            bus(1'b1, `EXI_OFS_FLAGS, 3);
            want[p] <= 1'b0;
            cyc(6);
            b = 2'(m != 3) << p;
            chk("irq_fall", irq, b);
            rdc("flag_fall", `EXI_OFS_FLAGS, b);
            bus(1'b1, `EXI_OFS_FLAGS, 3);
            rdc("flag_w1c", `EXI_OFS_FLAGS, 0);
            want[p] <= 1'b1;
            cyc(6);
            b = 2'(m != 2) << p;
            chk("irq_rise", irq, b);
            ack <= 5'(b);
            cyc(1);
            ack <= 5'h00;
            cyc(3);
            rdc("flag_ack", `EXI_OFS_FLAGS, 0);
         end
      end
      $display("test sense done");
   endtask
   task automatic t_sleep();
      bus(1'b1, `EXI_OFS_SENSE, `EXI_SNS_FALL);
      bus(1'b1, `EXI_OFS_MASK, 1);
      bus(1'b1, `EXI_OFS_PCCTL, 1);
      bus(1'b1, `EXI_OFS_PCM_LO, 1);
      io_run <= 1'b0;
      want[0] <= 1'b0;
      want[2] <= 1'b0;
      cyc(8);
      chk("irq_sleep", irq, 5'h04);
      bus(1'b1, `EXI_OFS_SENSE, `EXI_SNS_LOW);
      cyc(4);
      chk("irq_low", irq, 5'h05);
      want[0] <= 1'b1;
      ack <= 5'h04;
      io_run <= 1'b1;
      cyc(1);
      ack <= 5'h00;
      cyc(6);
      chk("irq_wake", irq, 0);
      $display("test sleep done");
   endtask
   task automatic t_groups();
      int pin[3] = '{7, 14, 16};
      bus(1'b1, `EXI_OFS_PCCTL, 7);
      bus(1'b1, `EXI_OFS_PCM_LO, 32'hFE);
      bus(1'b1, `EXI_OFS_PCM_HI, 32'hFF);
      want[2] <= 1'b1;
      want[17] <= 1'b0;
      cyc(6);
      rdc("pc_masked", `EXI_OFS_PCFLG, 0);
      for (int g = 0; g < 3; g++) begin
         want[2 + pin[g]] <= 1'b0;
         cyc(6);
         chk("irq_grp", irq, 5'h04 << g);
         rdc("pcflg", `EXI_OFS_PCFLG, 1 << g);
         bus(1'b1, `EXI_OFS_PCFLG, 7);
         rdc("pcflg_w1c", `EXI_OFS_PCFLG, 0);
      end
      $display("test groups done");
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      cyc(12);
      rst_n <= 1'b1;
      cyc(2);
      t_regs();
      t_level();
      t_sense();
      t_sleep();
      t_groups();
      summarize();
   end
   initial begin
      #50000;
      num_errors++;
      summarize();
   end
endmodule
`default_nettype wire
